// File: shared/rtc_defs.svh
/*
 holds the offsets, field positions, reset values and timing counts
 of the calendar clock unit; assumes a 200 MHz core clock.
*/
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
// apb byte offsets, one aligned word each
`define OFF_CTRL 8'h00
`define OFF_KEY 8'h04
`define OFF_CVH 8'h08
`define OFF_CVL 8'h0c
`define OFF_ACFG 8'h10
`define OFF_AVH 8'h14
`define OFF_AVL 8'h18
// control register bit positions
`define CTL_EN 7
`define CTL_WREN 5
`define CTL_SYNC 4
`define CTL_HALF 3
// unlock key values
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
// stored field masks per counter
`define MSK_MINUTE_SECOND_PAIR 8'h7f
`define MSK_HOUR 8'h3f
`define MSK_WDAY 8'h07
`define MSK_DAY 8'h3f
`define MSK_MON 8'h1f
// reset values of the calendar (bcd)
`define RST_DAY 8'h01
`define RST_MON 8'h01
`define RST_ZERO 8'h00
// timing: clock period and half-second span
`define CLK_PERIOD_PS 64'd5000
`define HALF_SEC_NS 64'd500000000
`define HALF_SEC_CYC (`HALF_SEC_NS * 64'd1000 / `CLK_PERIOD_PS)
`define SYNC_WIN_CYC 32
`endif

// File: shared/rtc_pkg.sv
/*
 holds the types of the calendar clock unit; assumes nothing else.
*/
package rtc_pkg;
   // apb data word
   typedef logic [31:0] word_t;
   // apb byte address
   typedef logic [7:0] addr_t;
   // one packed bcd byte
   typedef logic [7:0] bcd_t;
   // unlock sequence progress
   typedef enum logic [2:0] {
      KEY_IDLE = 3'b001,
      KEY_HALF = 3'b010,
      KEY_OPEN = 3'b100
   } key_state_t;
endpackage

// File: rtl/calendar_clock_unit.sv
/*
 calendar clock unit with four alarm pairs, apb slave with no wait states.
 assumes apb signals come from logic on clk_in.
*/
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "rtc_defs.svh"
module calendar_clock_unit #(
   parameter int HALF_CYC = int'(`HALF_SEC_CYC),
   parameter int SYNC_CYC = `SYNC_WIN_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire rtc_pkg::addr_t paddr_in,
   input wire rtc_pkg::word_t pwdata_in,
   output rtc_pkg::word_t prdata_out,
   output logic pready_out,
   output logic pslverr_out
);
   import rtc_pkg::*;
   localparam int PW = $clog2(HALF_CYC);
   localparam logic [PW-1:0] PRE_LAST = PW'(HALF_CYC - 1);
   localparam logic [PW-1:0] SYNC_AT = PW'(HALF_CYC - SYNC_CYC);

   // refuse prescaler and sync spans the logic cannot serve
   if (HALF_CYC < 2 || SYNC_CYC < 1 || SYNC_CYC >= HALF_CYC)
   begin : g_bad_span
      $error("bad half-second or sync span");
   end

   // next bcd value with wrap from last to first
   function automatic bcd_t bcd_inc(input bcd_t v, input bcd_t last,
                                    input bcd_t first);
      bcd_t r;
      r = v + 8'h01;
      if (v == last)
         r = first;
      else if (v[3:0] == 4'h9)
         r = {v[7:4] + 4'h1, 4'h0};
      return r;
   endfunction

   // a bcd year 00..99 divisible by four
   function automatic logic is_leap(input bcd_t y);
      logic even_tens;
      even_tens = ~y[4];
      if (even_tens)
         return y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8;
      return y[3:0] == 4'h2 || y[3:0] == 4'h6;
   endfunction

   // last day of a month in bcd
   function automatic bcd_t last_day(input bcd_t m, input bcd_t y);
      bcd_t r;
      case (m)
         8'h02: r = is_leap(y) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
         default: r = 8'h31;
      endcase
      return r;
   endfunction

   // prescaler stages: cycle count and half-second bit
   logic [PW-1:0] pre_q;
   logic half_q;
   // calendar counters, packed bcd
   bcd_t sec_q, min_q, hour_q, wday_q, day_q, mon_q, year_q;
   // control state
   logic en_q, wren_q;
   logic [1:0] cptr_q, aptr_q;
   key_state_t key_q;
   // alarm pairs, index {pointer, high}
   bcd_t alarm_q [0:7];
   // bus answer registers
   logic pready_q, pslverr_q;
   word_t prdata_q, rdata_d;

   // apb phases: setup answers next cycle, access completes
   wire setup = psel_in & ~penable_in & ~pready_q;
   wire acc = psel_in & penable_in & pready_q;
   wire wr = acc & pwrite_in;

   // address decode
   wire sel_ctl = paddr_in == `OFF_CTRL;
   wire sel_key = paddr_in == `OFF_KEY;
   wire sel_cvh = paddr_in == `OFF_CVH;
   wire sel_cvl = paddr_in == `OFF_CVL;
   wire sel_acfg = paddr_in == `OFF_ACFG;
   wire sel_avh = paddr_in == `OFF_AVH;
   wire sel_avl = paddr_in == `OFF_AVL;
   wire mapped = sel_ctl | sel_key | sel_cvh | sel_cvl | sel_acfg | sel_avh | sel_avl;
   wire [7:0] wb = pwdata_in[7:0];

   // gated time-window writes
   wire cw_hi = wr & sel_cvh & wren_q;
   wire cw_lo = wr & sel_cvl & wren_q;
   wire w_min = cw_hi & (cptr_q == 2'b00);
   wire w_sec = cw_lo & (cptr_q == 2'b00);
   wire w_wday = cw_hi & (cptr_q == 2'b01);
   wire w_hour = cw_lo & (cptr_q == 2'b01);
   wire w_mon = cw_hi & (cptr_q == 2'b10);
   wire w_day = cw_lo & (cptr_q == 2'b10);
   wire w_year = cw_lo & (cptr_q == 2'b11);
   wire w_minute_second_pair = w_min | w_sec;

   // carry chain from the second tick upward
   wire pre_end = en_q & (pre_q == PRE_LAST);
   wire c_sec = pre_end & half_q;
   wire c_min = c_sec & (sec_q == 8'h59);
   wire c_hour = c_min & (min_q == 8'h59);
   wire c_day = c_hour & (hour_q == 8'h23);
   wire c_mon = c_day & (day_q == last_day(mon_q, year_q));
   wire c_year = c_mon & (mon_q == 8'h12);

   // rollover pending near the second edge
   wire sync = en_q & half_q & (pre_q >= SYNC_AT);

   // alarm window indices
   wire [2:0] a_hi = {aptr_q, 1'b1};
   wire [2:0] a_lo = {aptr_q, 1'b0};
   wire a_mask = aptr_q == 2'b00;

   // prescaler, cleared by any minute/second write
   always_ff @(posedge clk_in)
   begin
      if (rst_in || w_minute_second_pair)
      begin
         pre_q <= '0;
         half_q <= 1'b0;
      end
      else if (pre_end)
      begin
         pre_q <= '0;
         half_q <= ~half_q;
      end
      else if (en_q)
      begin
         pre_q <= pre_q + PW'(1);
      end
   end

   // seconds and minutes: a write wins over the tick
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         sec_q <= `RST_ZERO;
         min_q <= `RST_ZERO;
      end
      else
      begin
         if (w_sec)
            sec_q <= wb & `MSK_MINUTE_SECOND_PAIR;
         else if (c_sec)
            sec_q <= bcd_inc(sec_q, 8'h59, 8'h00);
         if (w_min)
            min_q <= wb & `MSK_MINUTE_SECOND_PAIR;
         else if (c_min)
            min_q <= bcd_inc(min_q, 8'h59, 8'h00);
      end
   end

   // hours and weekday
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         hour_q <= `RST_ZERO;
         wday_q <= `RST_ZERO;
      end
      else
      begin
         if (w_hour)
            hour_q <= wb & `MSK_HOUR;
         else if (c_hour)
            hour_q <= bcd_inc(hour_q, 8'h23, 8'h00);
         if (w_wday)
            wday_q <= wb & `MSK_WDAY;
         else if (c_day)
            wday_q <= bcd_inc(wday_q, 8'h06, 8'h00);
      end
   end

   // day, month and year
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         day_q <= `RST_DAY;
         mon_q <= `RST_MON;
         year_q <= `RST_ZERO;
      end
      else
      begin
         if (w_day)
            day_q <= wb & `MSK_DAY;
         else if (c_day)
            day_q <= bcd_inc(day_q, last_day(mon_q, year_q), 8'h01);
         if (w_mon)
            mon_q <= wb & `MSK_MON;
         else if (c_mon)
            mon_q <= bcd_inc(mon_q, 8'h12, 8'h01);
         if (w_year)
            year_q <= wb;
         else if (c_year)
            year_q <= bcd_inc(year_q, 8'h99, 8'h00);
      end
   end

   // unlock sequence: each completed access moves it
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         key_q <= KEY_IDLE;
      else if (acc)
      begin
         if (wr && sel_key && wb == `KEY_FIRST)
            key_q <= KEY_HALF;
         else if (wr && sel_key && wb == `KEY_SECOND && key_q == KEY_HALF)
            key_q <= KEY_OPEN;
         else
            key_q <= KEY_IDLE;
      end
   end

   // control bits and clock pointer
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         en_q <= 1'b0;
         wren_q <= 1'b0;
         cptr_q <= 2'b00;
      end
      else if (wr && sel_ctl)
      begin
         en_q <= wb[`CTL_EN];
         // set only straight after the key pair, clear any time
         wren_q <= wb[`CTL_WREN] & (wren_q | key_q == KEY_OPEN);
         cptr_q <= wb[1:0];
      end
      else if (acc && sel_cvh && cptr_q != 2'b00)
         cptr_q <= cptr_q - 2'b01;
   end

   // alarm pointer and alarm storage
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         aptr_q <= 2'b00;
      else if (wr && sel_acfg)
         aptr_q <= wb[1:0];
      else if (acc && sel_avh && aptr_q != 2'b00)
         aptr_q <= aptr_q - 2'b01;
   end

   // alarm pairs hold software values, no reset
   always_ff @(posedge clk_in)
   begin
      if (wr && sel_avh)
         alarm_q[a_hi] <= a_mask ? (wb & `MSK_MINUTE_SECOND_PAIR) : wb;
      if (wr && sel_avl)
         alarm_q[a_lo] <= a_mask ? (wb & `MSK_MINUTE_SECOND_PAIR) : wb;
   end

   // read mux, byte in the low lane
   always_comb
   begin
      rdata_d = '0;
      if (sel_ctl)
         rdata_d[7:0] = {en_q, 1'b0, wren_q, sync, half_q, 1'b0, cptr_q};
      else if (sel_cvh)
      begin
         case (cptr_q)
            2'b00: rdata_d[7:0] = min_q;
            2'b01: rdata_d[7:0] = wday_q;
            2'b10: rdata_d[7:0] = mon_q;
            default: rdata_d[7:0] = 8'h00;
         endcase
      end
      else if (sel_cvl)
      begin
         case (cptr_q)
            2'b00: rdata_d[7:0] = sec_q;
            2'b01: rdata_d[7:0] = hour_q;
            2'b10: rdata_d[7:0] = day_q;
            default: rdata_d[7:0] = year_q;
         endcase
      end
      else if (sel_acfg)
         rdata_d[1:0] = aptr_q;
      else if (sel_avh)
         rdata_d[7:0] = alarm_q[a_hi] & (a_mask ? `MSK_MINUTE_SECOND_PAIR : 8'hff);
      else if (sel_avl)
         rdata_d[7:0] = alarm_q[a_lo] & (a_mask ? `MSK_MINUTE_SECOND_PAIR : 8'hff);
   end

   // bus answer: ready one cycle after setup
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end
      else
      begin
         pready_q <= setup;
         pslverr_q <= setup & ~mapped;
         prdata_q <= (setup && !pwrite_in) ? rdata_d : '0;
      end
   end
   assign pready_out = pready_q;
   assign pslverr_out = pslverr_q;
   assign prdata_out = prdata_q;
endmodule

// File: bench/calendar_clock_unit_assertions.sv
/*
 port checker for the calendar clock unit apb slave.
 assumes the zero-wait-state apb timing of the unit, bound below.
*/
`timescale 1ns/1ps
`include "rtc_defs.svh"
module calendar_clock_unit_assertions (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // answer comes in the cycle after setup
   property p_ans; psel_in && !penable_in && !pready_out |=> pready_out; endproperty
   a_ans: assert property (p_ans) else $error("no answer after setup");
   property p_pulse; pready_out |=> !pready_out; endproperty
   a_pulse: assert property (p_pulse) else $error("ready held too long");
   property p_errrdy; pslverr_out |-> pready_out; endproperty
   a_errrdy: assert property (p_errrdy) else $error("error flag without ready");
   property p_setup; pready_out |-> $past(psel_in && !penable_in); endproperty
   a_setup: assert property (p_setup) else $error("ready without setup");
   property p_hi; prdata_out[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_idle; !(pready_out && !pwrite_in) |-> prdata_out == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data outside answer");
   property p_err; pready_out && paddr_in > `OFF_AVL |-> pslverr_out; endproperty
   a_err: assert property (p_err) else $error("unmapped not flagged");
   property p_noerr; pready_out && paddr_in <= `OFF_AVL && paddr_in[1:0] == 2'b00 |-> !pslverr_out; endproperty
   a_noerr: assert property (p_noerr) else $error("mapped access flagged");
   property p_key; pready_out && !pwrite_in && paddr_in == `OFF_KEY |-> prdata_out == 32'h0; endproperty
   a_key: assert property (p_key) else $error("key register readable");
   c_wr: cover property (pready_out && pwrite_in);
   c_err: cover property (pready_out && pslverr_out);
   c_rd: cover property (pready_out && !pwrite_in && paddr_in == `OFF_CVL);
endmodule
bind calendar_clock_unit calendar_clock_unit_assertions chk_i (.clk_in, .rst_in, .psel_in, .penable_in,
   .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out);

// File: bench/calendar_clock_unit_tb.sv
/*
 self-checking bench for the calendar clock unit.
 assumes a short half second (8 cycles) and the apb map of rtc_defs.
*/
`timescale 1ns/1ps
`include "rtc_defs.svh"
module calendar_clock_unit_tb;
   import rtc_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   addr_t paddr_in = 8'h00;
   word_t pwdata_in = 32'h0;
   word_t prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic serr;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   calendar_clock_unit #(.HALF_CYC(8), .SYNC_CYC(2)) dut (.clk_in(clk_in), .rst_in(rst_in),
      .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out));
   initial forever #2.5 clk_in = ~clk_in;
   // hang guard
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input word_t e, input word_t g);
      checks++;
      if (g !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, then one idle cycle
   task automatic xfer(input logic w, input addr_t a, input word_t d, output word_t r);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      // no cycle count assumed: only the hang guard ends this wait
      do
         @(posedge clk_in);
      while (pready_out !== 1'b1);
      r = prdata_out;
      serr = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic wr(input addr_t a, input word_t d);
      word_t r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rc(input addr_t a, input word_t e, input string nm);
      word_t r;
      xfer(1'b0, a, 32'h0, r);
      chk(nm, e, r);
   endtask
   task automatic unlock();
      wr(`OFF_KEY, 32'h55);
      wr(`OFF_KEY, 32'haa);
      wr(`OFF_CTRL, 32'h20);
   endtask
   task automatic t_lock();
      rc(`OFF_CTRL, 32'h0, "ctrl");
      rc(`OFF_CVL, 32'h0, "sec");
      wr(`OFF_CVL, 32'h25);
      rc(`OFF_CVL, 32'h0, "locked sec");
      wr(`OFF_KEY, 32'h55);
      wr(`OFF_KEY, 32'haa);
      rc(`OFF_KEY, 32'h0, "key");
      wr(`OFF_CTRL, 32'h20);
      rc(`OFF_CTRL, 32'h0, "late enable");
      unlock();
      rc(`OFF_CTRL, 32'h20, "enable");
      wr(`OFF_CVL, 32'h25);
      rc(`OFF_CVL, 32'h25, "sec");
      $display("t_lock done");
   endtask
   // loads year, feb 28, 23:59:59 through the pointer windows
   task automatic set_time(input bcd_t y);
      wr(`OFF_CTRL, 32'h23);
      wr(`OFF_CVL, {24'h0, y});
      wr(`OFF_CVH, 32'h77);
      wr(`OFF_CVL, 32'h28);
      wr(`OFF_CVH, 32'h02);
      wr(`OFF_CVL, 32'h23);
      wr(`OFF_CVH, 32'h00);
      wr(`OFF_CVH, 32'h59);
      wr(`OFF_CVL, 32'h59);
      rc(`OFF_CTRL, 32'h20, "pointer");
   endtask
   task automatic t_clock();
      bcd_t yr[2] = '{8'h24, 8'h23};
      bcd_t ed[2] = '{8'h29, 8'h01};
      bcd_t em[2] = '{8'h02, 8'h03};
      for (int i = 0; i < 2; i++)
      begin
         set_time(yr[i]);
         wr(`OFF_CTRL, 32'ha0);
         repeat (20) @(posedge clk_in);
         wr(`OFF_CTRL, 32'h22);
         rc(`OFF_CVL, {24'h0, ed[i]}, "day");
         rc(`OFF_CVL, {24'h0, ed[i]}, "day reread");
         rc(`OFF_CVH, {24'h0, em[i]}, "month");
         rc(`OFF_CVL, 32'h0, "hour");
         rc(`OFF_CVH, 32'h01, "weekday");
         rc(`OFF_CVH, 32'h0, "minute");
      end
      wr(`OFF_CTRL, 32'h23);
      rc(`OFF_CVL, 32'h23, "year");
      rc(`OFF_CVH, 32'h0, "year high");
      $display("t_clock done");
   endtask
   // second tick, half-second bit and sync window from a cleared prescaler
   task automatic t_sync();
      wr(`OFF_CTRL, 32'h20);
      wr(`OFF_CVL, 32'h10);
      wr(`OFF_CTRL, 32'ha0);
      rc(`OFF_CTRL, 32'ha0, "no sync");
      repeat (5) @(posedge clk_in);
      rc(`OFF_CTRL, 32'ha8, "half second");
      repeat (2) @(posedge clk_in);
      rc(`OFF_CTRL, 32'hb8, "sync");
      rc(`OFF_CVL, 32'h11, "second tick");
      wr(`OFF_CTRL, 32'h03);
      wr(`OFF_CVL, 32'h55);
      rc(`OFF_CVL, 32'h23, "locked year");
      $display("t_sync done");
   endtask
   task automatic t_alarm();
      wr(`OFF_ACFG, 32'h0);
      wr(`OFF_AVH, 32'hd9);
      wr(`OFF_AVL, 32'ha7);
      rc(`OFF_AVH, 32'h59, "alarm min");
      rc(`OFF_AVL, 32'h27, "alarm sec");
      wr(`OFF_ACFG, 32'h2);
      wr(`OFF_AVH, 32'h0);
      rc(`OFF_ACFG, 32'h1, "alarm ptr");
      rc(8'h1c, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, serr});
      $display("t_alarm done");
   endtask
   initial
   begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      t_lock();
      t_clock();
      t_sync();
      t_alarm();
      stop_test();
   end
endmodule
